// ### include/drf_map.svh
`ifndef DRF_MAP_SVH
`define DRF_MAP_SVH
// ============================================================
// register offsets (byte addresses) of the controller
`define DRF_OFF_CTRL 8'h00
`define DRF_OFF_MODE2 8'h04
`define DRF_OFF_MODE3 8'h08
`define DRF_OFF_STAT 8'h0C
`define DRF_OFF_DEV 8'h10
// ============================================================
// control register fields
`define DRF_CTRL_REF_EN 0
`define DRF_CTRL_SR 1
`define DRF_CTRL_WR_MODE2 2
`define DRF_CTRL_WR_MODE3 3
`define DRF_CTRL_PULL 4
// ============================================================
// mode register fields
`define DRF_AUTO_SR_BIT 6
`define DRF_SR_RANGE_BIT 7
`define DRF_READOUT_EN_BIT 2
`define DRF_MODE3_RSV_MASK 15'h7FF8
`define DRF_MODE2_RSV_MASK 15'h7900
// ============================================================
// timing, in ns, and cycles at 100 ns
`define DRF_CLK_NS 100
`define DRF_REFI_NS 7800
`define DRF_RFC_NS 160
`define DRF_PRE_NS 14
`define DRF_REFI_CYC ((`DRF_REFI_NS) / (`DRF_CLK_NS))
`define DRF_RFC_CYC (((`DRF_RFC_NS) + (`DRF_CLK_NS) - 1) / (`DRF_CLK_NS))
`define DRF_PRE_CYC (((`DRF_PRE_NS) + (`DRF_CLK_NS) - 1) / (`DRF_CLK_NS))
// ============================================================
// refresh accounting limits
`define DRF_MAX_POSTPONE 8
`define DRF_MAX_PULLIN 8
`define DRF_MAX_IN_2REFI 16
`define DRF_READOUT_PATTERN 8'h55
`define DRF_CNT_W 8
`endif

// ### include/drf_pkg.sv
package drf_pkg;
  typedef enum logic [2:0] {
    DRF_CMD_DESEL,
    DRF_CMD_NOP,
    DRF_CMD_MRS,
    DRF_CMD_REF,
    DRF_CMD_SRE,
    DRF_CMD_RD,
    DRF_CMD_OTHER
  } drf_cmd_e;
  typedef logic [14:0] drf_addr_t;
  typedef logic [2:0] drf_bank_t;
  typedef logic [7:0] drf_data_t;
endpackage

// ### include/drf_if.sv
`timescale 1ns/1ns
`default_nettype none
interface drf_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic [2:0] ba;
  logic [14:0] addr;
  logic [7:0] dq;
  logic dq_valid;
  modport ctrl (
    output cs_n, ras_n, cas_n, we_n, cke, ba, addr,
    input dq, dq_valid
  );
  modport dev (
    input cs_n, ras_n, cas_n, we_n, cke, ba, addr,
    output dq, dq_valid
  );
endinterface
`default_nettype wire

// ### design/drf_cmd_decode.sv
`timescale 1ns/1ns
`default_nettype none
module drf_cmd_decode (
  // command pins
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  // decoded command
  output drf_pkg::drf_cmd_e cmd
);
  import drf_pkg::*;
  always_comb begin
    if (cs_n) begin
      cmd = DRF_CMD_DESEL;
    end else begin
      unique case ({ras_n, cas_n, we_n})
        3'h0: cmd = DRF_CMD_MRS;
        3'h1: cmd = cke ? DRF_CMD_REF : DRF_CMD_SRE; // RQ13
        3'h5: cmd = DRF_CMD_RD;
        3'h7: cmd = DRF_CMD_NOP;
        default: cmd = DRF_CMD_OTHER;
      endcase
    end
  end
endmodule // drf_cmd_decode
`default_nettype wire

// ### design/drf_dev.sv
`timescale 1ns/1ns
`default_nettype none
`include "drf_map.svh"
module drf_dev (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // link
  drf_if.dev link,
  // state seen by the user
  output logic auto_sr_on,
  output logic sr_range_on,
  output logic [1:0] sr_rate,
  output logic readout_on,
  output logic [1:0] readout_loc,
  output logic in_self_refresh,
  output logic [14:0] row_ctr,
  output logic banks_idle,
  output logic mode_err
);
  import drf_pkg::*;
  drf_cmd_e cmd;
  logic [14:0] mode2_reg;
  logic [14:0] mode3_reg;
  logic [7:0] rfc_reg;

  drf_cmd_decode u_dec (
    .cs_n(link.cs_n),
    .ras_n(link.ras_n),
    .cas_n(link.cas_n),
    .we_n(link.we_n),
    .cke(link.cke),
    .cmd(cmd)
  );

  // ============================================================
  // mode registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode2_reg <= 15'h0;
      mode3_reg <= 15'h0;
    end else if (cmd == DRF_CMD_MRS && link.ba[1:0] == 2'h3) begin
      mode3_reg <= link.addr; // RQ1
    end else if (cmd == DRF_CMD_MRS && link.ba[1:0] == 2'h2) begin
      mode2_reg <= link.addr;
    end
  end
  assign auto_sr_on = mode2_reg[`DRF_AUTO_SR_BIT]; // RQ5
  assign sr_range_on = mode2_reg[`DRF_SR_RANGE_BIT];
  assign mode_err = auto_sr_on & sr_range_on;
  // 0 normal rate, 1 extended rate, 2 temperature tracking
  assign sr_rate = auto_sr_on ? 2'h2 : (sr_range_on ? 2'h1 : 2'h0); // RQ6 RQ9
  assign readout_on = mode3_reg[`DRF_READOUT_EN_BIT];
  assign readout_loc = readout_on ? mode3_reg[1:0] : 2'h0; // RQ3

  // ============================================================
  // refresh: internal row counter, busy timer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      row_ctr <= 15'h0;
    end else if (cmd == DRF_CMD_REF) begin
      row_ctr <= row_ctr + 15'h1; // RQ15
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rfc_reg <= 8'h0;
    end else if (cmd == DRF_CMD_REF) begin
      rfc_reg <= 8'(`DRF_RFC_CYC);
    end else if (rfc_reg != 8'h0) begin
      rfc_reg <= rfc_reg - 8'h1;
    end
  end
  // idle again once the refresh cycle ends
  assign banks_idle = (rfc_reg == 8'h0); // RQ16

  // ============================================================
  // self-refresh: held while cke stays low; partial retention
  // loss is not modelled since no array is stored here
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      in_self_refresh <= 1'b0;
    end else if (cmd == DRF_CMD_SRE) begin
      in_self_refresh <= 1'b1; // RQ12
    end else if (link.cke) begin
      in_self_refresh <= 1'b0;
    end
  end

  // ============================================================
  // readout pattern for read capture training
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      link.dq <= 8'h0;
      link.dq_valid <= 1'b0;
    end else begin
      link.dq_valid <= (cmd == DRF_CMD_RD) && readout_on; // RQ4
      link.dq <= (cmd == DRF_CMD_RD && readout_on) ?
        `DRF_READOUT_PATTERN : 8'h0;
    end
  end
endmodule // drf_dev
`default_nettype wire

// ### design/drf_ctrl.sv
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "drf_map.svh"
// Behaviour
// RQ1 - mode write, both bank bits: register three
// RQ2 - register three reserved bits driven zero
// RQ3 - readout disabled ignores readout location
// RQ4 - readout reads return fixed pattern
// RQ5 - auto self refresh: bit6 one, bit7 zero
// RQ6 - auto mode scales power with temperature
// RQ7 - no auto support means bit6 zero
// RQ8 - without auto mode, program temperature range
// RQ9 - range bit chooses normal or extended rate
// RQ10 - auto mode and range both set illegal
// RQ11 - no extended range keeps bit7 zero
// RQ12 - partial retention loses data in self-refresh
// RQ13 - refresh decoded as cs ras cas low
// RQ14 - banks idle precharge time before refresh
// RQ15 - refresh rows come from internal counter
// RQ16 - refresh leaves banks precharged idle
// RQ17 - only nop or deselect during refresh cycle
// RQ18 - one refresh per average interval
// RQ19 - at most eight refreshes postponed
// RQ20 - at most eight pulled in credited
// RQ21 - at most sixteen refreshes per two intervals
// RQ22 - debt frozen during self-refresh
module drf_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // capability straps
  input wire logic auto_sr_supported,
  input wire logic ext_temp_supported,
  // link
  drf_if.ctrl link
);
  import drf_pkg::*;
  typedef enum logic [2:0] {
    DRF_IDLE, DRF_PRE_WAIT, DRF_REF_BUSY, DRF_SELF, DRF_MRS_ISSUE
  } drf_state_e;
  drf_state_e state_reg;
  logic [7:0] ctrl_reg;
  logic [14:0] mode2_reg;
  logic [14:0] mode3_reg;
  logic [15:0] refi_cnt_reg;
  logic [7:0] wait_reg;
  logic signed [7:0] debt_reg;
  logic [4:0] win_cnt_reg;
  logic [4:0] win_prev_reg;
  logic [2:0] mrs_pend_reg;
  logic wr_ph_reg;
  logic rd_ph_reg;
  logic [7:0] addr_ph_reg;
  logic issue_ref;
  logic tick;
  logic [14:0] mode2_safe;
  logic [14:0] mode3_safe;

  // ============================================================
  // ahb-lite: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ph_reg <= 1'b0;
      rd_ph_reg <= 1'b0;
      addr_ph_reg <= 8'h0;
    end else if (hready) begin
      wr_ph_reg <= hsel && htrans[1] && hwrite;
      rd_ph_reg <= hsel && htrans[1] && !hwrite;
      addr_ph_reg <= haddr;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0;
    end else if (hsel && htrans[1] && !hwrite && hready) begin
      unique case (haddr)
        `DRF_OFF_CTRL: hrdata <= {24'h0, ctrl_reg};
        `DRF_OFF_MODE2: hrdata <= {17'h0, mode2_reg};
        `DRF_OFF_MODE3: hrdata <= {17'h0, mode3_reg};
        `DRF_OFF_STAT: hrdata <= {8'h0, 3'h0, win_cnt_reg,
          debt_reg, 5'h0, 3'(state_reg)};
        default: hrdata <= 32'h0;
      endcase
    end
  end
  // legal settings only reach the device
  always_comb begin
    mode2_safe = mode2_reg & ~`DRF_MODE2_RSV_MASK;
    if (!auto_sr_supported) begin
      mode2_safe[`DRF_AUTO_SR_BIT] = 1'b0; // RQ7
    end
    if (mode2_safe[`DRF_AUTO_SR_BIT] || !ext_temp_supported) begin
      mode2_safe[`DRF_SR_RANGE_BIT] = 1'b0; // RQ10 RQ11
    end
    // without auto mode the programmed range is passed through as is when ext_temp_supported is set
    mode3_safe = mode3_reg & ~`DRF_MODE3_RSV_MASK; // RQ2
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= 8'h0;
      mode2_reg <= 15'h0;
      mode3_reg <= 15'h0;
    end else if (wr_ph_reg) begin
      unique case (addr_ph_reg)
        `DRF_OFF_CTRL: ctrl_reg <= hwdata[7:0];
        `DRF_OFF_MODE2: mode2_reg <= hwdata[14:0]; // RQ8
        `DRF_OFF_MODE3: mode3_reg <= hwdata[14:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end else begin
      ctrl_reg[`DRF_CTRL_WR_MODE2] <= 1'b0;
      ctrl_reg[`DRF_CTRL_WR_MODE3] <= 1'b0;
      ctrl_reg[`DRF_CTRL_PULL] <= 1'b0;
    end
  end

  // ============================================================
  // refresh interval tick and debt accounting
  assign tick = (refi_cnt_reg == 16'(`DRF_REFI_CYC - 1));
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      refi_cnt_reg <= 16'h0;
    end else if (tick) begin
      refi_cnt_reg <= 16'h0;
    end else begin
      refi_cnt_reg <= refi_cnt_reg + 16'h1;
    end
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      debt_reg <= 8'sh0;
    end else if (state_reg == DRF_SELF) begin
      debt_reg <= debt_reg; // RQ22
    end else if (issue_ref && !(tick && ctrl_reg[`DRF_CTRL_REF_EN])) begin
      // credit stops at eight pulled in
      if (debt_reg > -8'sd`DRF_MAX_PULLIN) begin
        debt_reg <= debt_reg - 8'sh1; // RQ20
      end
    end else if (tick && !issue_ref && ctrl_reg[`DRF_CTRL_REF_EN]) begin
      debt_reg <= debt_reg + 8'sh1; // RQ18
    end
  end
  // refreshes in the current and previous interval
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      win_cnt_reg <= 5'h0;
      win_prev_reg <= 5'h0;
    end else if (tick) begin
      win_prev_reg <= win_cnt_reg;
      win_cnt_reg <= {4'h0, issue_ref};
    end else if (issue_ref) begin
      win_cnt_reg <= win_cnt_reg + 5'h1;
    end
  end

  // ============================================================
  // command sequencer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mrs_pend_reg <= 3'h0;
    end else if (ctrl_reg[`DRF_CTRL_WR_MODE3]) begin
      mrs_pend_reg <= 3'h3;
    end else if (ctrl_reg[`DRF_CTRL_WR_MODE2]) begin
      mrs_pend_reg <= 3'h2;
    end else if (state_reg == DRF_MRS_ISSUE) begin
      mrs_pend_reg <= 3'h0;
    end
  end
  // a refresh is due at positive debt, or pulled in on request
  assign issue_ref = (state_reg == DRF_PRE_WAIT) && (wait_reg == 8'h0)
    && ({3'h0, win_cnt_reg} + {3'h0, win_prev_reg}
    < 8'(`DRF_MAX_IN_2REFI)); // RQ21
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= DRF_IDLE;
      wait_reg <= 8'h0;
    end else begin
      unique case (state_reg)
        DRF_IDLE: begin
          // a pull-in request is honoured with refresh enable off too
          if ((ctrl_reg[`DRF_CTRL_REF_EN] && (debt_reg > 8'sh0
              || debt_reg >= 8'sd`DRF_MAX_POSTPONE)) // RQ19
              || ctrl_reg[`DRF_CTRL_PULL]) begin
            state_reg <= DRF_PRE_WAIT;
            wait_reg <= 8'(`DRF_PRE_CYC); // RQ14
          end else if (ctrl_reg[`DRF_CTRL_SR]
              && !ctrl_reg[`DRF_CTRL_REF_EN]) begin
            state_reg <= DRF_SELF; // RQ22
          end else if (mrs_pend_reg != 3'h0) begin
            state_reg <= DRF_MRS_ISSUE;
          end
        end
        DRF_PRE_WAIT: begin
          if (wait_reg != 8'h0) begin
            wait_reg <= wait_reg - 8'h1;
          end else if (issue_ref) begin
            state_reg <= DRF_REF_BUSY;
            wait_reg <= 8'(`DRF_RFC_CYC); // RQ17
          end
        end
        DRF_REF_BUSY: begin
          if (wait_reg != 8'h0) begin
            wait_reg <= wait_reg - 8'h1;
          end else begin
            state_reg <= DRF_IDLE;
          end
        end
        DRF_SELF: begin
          if (!ctrl_reg[`DRF_CTRL_SR]) begin
            state_reg <= DRF_IDLE;
          end
        end
        DRF_MRS_ISSUE: state_reg <= DRF_IDLE;
      endcase
    end
  end

  // ============================================================
  // pins: nop by default; strobes, ba and addr change only for refresh, self-refresh entry and mode write; cke is low from self-refresh entry until exit
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      link.cs_n <= 1'b1;
      link.ras_n <= 1'b1;
      link.cas_n <= 1'b1;
      link.we_n <= 1'b1;
      link.cke <= 1'b1;
      link.ba <= 3'h0;
      link.addr <= 15'h0;
    end else begin
      link.cs_n <= 1'b0;
      link.ras_n <= 1'b1;
      link.cas_n <= 1'b1;
      link.we_n <= 1'b1;
      link.cke <= (state_reg != DRF_SELF);
      link.ba <= 3'h0;
      link.addr <= 15'h0;
      if (issue_ref) begin
        link.ras_n <= 1'b0; // RQ13
        link.cas_n <= 1'b0;
      end else if (state_reg == DRF_IDLE && ctrl_reg[`DRF_CTRL_SR]
          && !ctrl_reg[`DRF_CTRL_REF_EN]) begin
        link.ras_n <= 1'b0;
        link.cas_n <= 1'b0;
        link.cke <= 1'b0;
      end else if (state_reg == DRF_MRS_ISSUE) begin
        link.ras_n <= 1'b0;
        link.cas_n <= 1'b0;
        link.we_n <= 1'b0;
        link.ba <= {1'b0, mrs_pend_reg[1:0]}; // RQ1
        link.addr <= mrs_pend_reg[0] ? mode3_safe : mode2_safe;
      end
    end
  end
endmodule // drf_ctrl
`default_nettype wire

// ### verif/drf_link_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module drf_link_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // command bus
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic [2:0] ba,
  input wire logic [14:0] addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  localparam int WIN = 156;
  logic ref_c;
  logic mrs_c;
  logic idle_c;
  logic [7:0] win_t;
  logic [4:0] win_n;
  assign ref_c = !cs_n && !ras_n && !cas_n && we_n && cke;
  assign mrs_c = !cs_n && !ras_n && !cas_n && !we_n;
  assign idle_c = cs_n || (ras_n && cas_n && we_n);
  // ============================================================
  // refresh count per fixed window of two intervals
  // fixed windows are weaker than sliding ones, but cheap to count
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      win_t <= 8'h00;
      win_n <= 5'h00;
    end else if (win_t == 8'(WIN - 1)) begin
      win_t <= 8'h00;
      win_n <= {4'h0, ref_c};
    end else begin
      win_t <= win_t + 8'h01;
      win_n <= win_n + {4'h0, ref_c};
    end
  end
  // ============================================================
  // command bus properties
  chk_mrs_bank_sel: assert property (mrs_c |-> ba[1])
    else $error("mode write to unexpected bank");
  chk_mr3_rsvd_addr: assert property (
    mrs_c && ba[1:0] == 2'h3 |-> addr[14:3] == 12'h000)
    else $error("mode three reserved address bits set");
  chk_mr3_rsvd_bank: assert property (
    mrs_c && ba[1:0] == 2'h3 |-> !ba[2])
    else $error("mode three reserved bank bit set");
  chk_mr2_asr_srt: assert property (
    mrs_c && ba == 3'h2 |-> !(addr[6] && addr[7]))
    else $error("illegal auto refresh and range pair");
  chk_ref_cke_held: assert property (ref_c |-> $past(cke))
    else $error("refresh without clock enable held");
  chk_ref_precharged: assert property (ref_c |-> $past(idle_c))
    else $error("refresh without idle precharge gap");
  chk_ref_nop_gap: assert property (ref_c |=> idle_c [*2])
    else $error("command inside refresh cycle time");
  chk_ref_two_intv: assert property (ref_c |-> win_n < 5'd16)
    else $error("more than sixteen refreshes in window");
  cover property (ref_c);
  cover property (mrs_c && ba == 3'h3);
  cover property (mrs_c && ba == 3'h2);
  cover property ($fell(cke));
endmodule // drf_link_chk
`default_nettype wire

// ### verif/tb_ddr3_refresh_and_mpr_config.sv
`timescale 1ns/1ns
`default_nettype none
`include "drf_map.svh"
module tb_ddr3_refresh_and_mpr_config;
  logic core_clk, resetn, hsel, hwrite, auto_sup, ext_sup, hreadyout, hresp;
  logic auto_on, range_on, rdo_on, in_sr, banks_idle, mode_err;
  logic [7:0] haddr;
  logic [1:0] htrans, sr_rate, rdo_loc;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, st;
  logic [14:0] row_ctr;
  logic [8:0] tbl [6];
  int bad_count = 0;
  int num_checks = 0;
  int refs = 0;
  drf_if lk();
  drf_ctrl drf_ctrl_i (.core_clk(core_clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .auto_sr_supported(auto_sup),
    .ext_temp_supported(ext_sup), .link(lk));
  drf_dev drf_dev_i (.core_clk(core_clk), .resetn(resetn), .link(lk),
    .auto_sr_on(auto_on), .sr_range_on(range_on), .sr_rate(sr_rate),
    .readout_on(rdo_on), .readout_loc(rdo_loc), .in_self_refresh(in_sr),
    .row_ctr(row_ctr),
    .banks_idle(banks_idle), .mode_err(mode_err));
  drf_link_chk drf_link_chk_i (.core_clk(core_clk), .resetn(resetn),
    .cs_n(lk.cs_n), .ras_n(lk.ras_n), .cas_n(lk.cas_n), .we_n(lk.we_n),
    .cke(lk.cke), .ba(lk.ba), .addr(lk.addr));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // count refresh commands seen on the wire
  always @(posedge core_clk) begin
    if (resetn && !lk.cs_n && !lk.ras_n && !lk.cas_n && lk.we_n && lk.cke) begin
      refs++;
    end
  end
  // ============================================================
  // bus tasks, entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0, st);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(posedge core_clk);
    do begin
      rd(`DRF_OFF_STAT);
      n++;
    end while (st[2:0] !== 3'h0 && n < 40);
    chk(32'(st[2:0]), 32'h0);
  endtask
  task automatic wait_sr(input logic v);
    int n;
    n = 0;
    while (in_sr !== v && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(in_sr), 32'(v));
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    summarize();
  end
  // ============================================================
  // test sequence
  initial begin
    int i;
    int r0;
    logic [7:0] d0;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    auto_sup = 1'b0;
    ext_sup = 1'b0;
    tbl = '{9'h1B4, 9'h1F4, 9'h0A0, 9'h0CA, 9'h140, 9'h000};
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    chk(32'({auto_on, range_on, sr_rate, rdo_on, rdo_loc, in_sr, mode_err,
      banks_idle}), 32'h1);
    // readout select, reserved bits set in the image on purpose
    for (i = 0; i < 5; i++) begin
      wr(`DRF_OFF_MODE3, (i < 4) ? (32'h7FFC | 32'(i)) : 32'h7FFB);
      wr(`DRF_OFF_CTRL, 32'h8);
      wait_idle();
      chk(32'({rdo_on, rdo_loc}), (i < 4) ? 32'(4 | i) : 32'h0);
    end
    // auto refresh and range against the straps
    for (i = 0; i < 6; i++) begin
      auto_sup <= tbl[i][8];
      ext_sup <= tbl[i][7];
      wr(`DRF_OFF_MODE2, 32'(tbl[i][6:5]) << 6);
      wr(`DRF_OFF_CTRL, 32'h4);
      wait_idle();
      chk(32'({auto_on, range_on, sr_rate, mode_err}),
        32'(tbl[i][4:0]));
    end
    // pull in far more than can be credited
    for (i = 0; i < 20; i++) begin
      wr(`DRF_OFF_CTRL, 32'h10);
      wait_idle();
    end
    rd(`DRF_OFF_STAT);
    chk(32'(st[15:8]), 32'hF8);
    chk(32'(row_ctr), 32'(refs[14:0]));
    chk(32'(banks_idle), 32'h1);
    r0 = refs;
    wr(`DRF_OFF_CTRL, 32'h1);
    for (i = 0; i < 20; i++) begin
      repeat (78) @(posedge core_clk);
      rd(`DRF_OFF_STAT);
      chk(32'($signed(st[15:8]) <= 8), 32'h1);
      chk(32'(st[20:16] <= 5'd16), 32'h1);
    end
    chk(32'(refs >= r0 + 4), 32'h1);
    chk(32'(row_ctr), 32'(refs[14:0]));
    // self refresh keeps the debt
    wr(`DRF_OFF_CTRL, 32'h0);
    wait_idle();
    rd(`DRF_OFF_STAT);
    d0 = st[15:8];
    wr(`DRF_OFF_CTRL, 32'h2);
    wait_sr(1'b1);
    chk(32'(lk.cke), 32'h0);
    repeat (160) @(posedge core_clk);
    rd(`DRF_OFF_STAT);
    chk(32'(st[15:8]), 32'(d0));
    wr(`DRF_OFF_CTRL, 32'h0);
    wait_sr(1'b0);
    chk(32'(lk.cke), 32'h1);
    // unmapped places read zero
    wr(`DRF_OFF_DEV, 32'hFFFF_FFFF);
    rd(`DRF_OFF_DEV);
    chk(st, 32'h0);
    rd(8'h14);
    chk(st, 32'h0);
    summarize();
  end
endmodule // tb_ddr3_refresh_and_mpr_config
`default_nettype wire
